// ---- pos_steer.sv ----
// PWM output steering for one enhanced capture/compare/PWM channel
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pos_steer
    import pos_pkg::*;
(
    input  wire logic        MCLK_I,          // System clock, 20 MHz
    input  wire logic        SYS_RST_I,       // Synchronous reset, active high
    input  wire logic        HSEL_I,          // AHB slave select
    input  wire logic [7:0]  HADDR_I,         // AHB byte address
    input  wire logic [1:0]  HTRANS_I,        // AHB transfer type
    input  wire logic        HWRITE_I,        // AHB write
    input  wire logic [2:0]  HSIZE_I,         // AHB size, word only
    input  wire logic [31:0] HWDATA_I,        // AHB write data
    input  wire logic        HREADY_I,        // AHB bus ready
    output logic      [31:0] HRDATA_O,        // AHB read data
    output logic             HREADYOUT_O,     // Always ready
    output logic             HRESP_O,         // Always OKAY
    input  wire logic        PWM_I,           // Raw PWM waveform
    input  wire logic        PERIOD_START_I,  // Pulse at PWM period start
    input  wire logic [3:0]  PORT_DATA_I,     // Port data per pin, A at 0
    input  wire logic [3:0]  PORT_DIR_IN_I,   // Port direction, 1 is input
    output logic      [3:0]  PIN_OUT_O,       // Pin output level
    output logic      [3:0]  PIN_OE_N_O       // Pin enable, low drives
);

    pos_state_t st_reg;
    pos_state_t st_next;

    // Decode of a bus address phase
    function automatic logic bus_phase(input logic sel, input logic [1:0] tr,
                                       input logic rdy);
        return sel && rdy && (tr == HTRANS_NONSEQ);
    endfunction

    logic       steer_mode;   // Steering allowed by config
    logic [3:0] new_sel;      // Enables from the control register
    logic       pol_a;        // Polarity for A and C
    logic       pol_b;        // Polarity for B and D
    logic [7:0] wr_ctrl;      // Control after write this cycle
    logic [7:0] wr_cfg;       // Config after write this cycle

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        st_next = st_reg;
        wr_ctrl = st_reg.ctrl;
        wr_cfg  = st_reg.ccp_cfg;
        // Write data phase lands in registers
        if (st_reg.wr.valid) begin
            if (st_reg.wr.addr == STEER_CTRL_ADDR) begin
                wr_ctrl = HWDATA_I[7:0] & STEER_CTRL_MASK;
            end
            if (st_reg.wr.addr == CCP_CFG_ADDR) begin
                wr_cfg = {2'b00, HWDATA_I[5:0]};
            end
        end
        st_next.ctrl    = wr_ctrl;
        st_next.ccp_cfg = wr_cfg;
        st_next.wr.valid = 1'b0;
        // Address phase capture; the slave never stalls
        if (bus_phase(HSEL_I, HTRANS_I, HREADY_I)) begin
            st_next.wr.valid = HWRITE_I;
            st_next.wr.addr  = HADDR_I;
            st_next.rd_addr  = HADDR_I;
            if (!HWRITE_I) begin
                // Read sees a write whose data phase lands in this same cycle
                unique case (HADDR_I)
                    STEER_CTRL_ADDR: st_next.hrdata = {24'h000000, wr_ctrl};
                    CCP_CFG_ADDR:    st_next.hrdata = {24'h000000, wr_cfg};
                    STEER_STAT_ADDR: st_next.hrdata = {26'h0000000, st_reg.pending,
                                                       steer_mode, st_reg.applied};
                    default:         st_next.hrdata = 32'h00000000;
                endcase
            end
        end
        // Apply selection: immediate or deferred to the period start
        if (wr_ctrl[STEER_SYNC_BIT]) begin
            if (PERIOD_START_I) begin
                st_next.applied = wr_ctrl[STEER_D_BIT:STEER_A_BIT];
                st_next.pending = 1'b0;
            end else begin
                // Flag drops again if software writes back the set in effect
                st_next.pending = (wr_ctrl[STEER_D_BIT:STEER_A_BIT] != st_reg.applied);
            end
        end else begin
            st_next.applied = wr_ctrl[STEER_D_BIT:STEER_A_BIT];
            st_next.pending = 1'b0;
        end
        // Pin muxing per output
        for (int i = 0; i < 4; i++) begin
            if (steer_mode && st_reg.applied[i]) begin
                st_next.pin_out[i]  = PWM_I ^ ((i % 2 == 0) ? pol_a : pol_b);
                st_next.pin_oe_n[i] = 1'b0;
            end else begin
                st_next.pin_out[i]  = PORT_DATA_I[i];
                st_next.pin_oe_n[i] = PORT_DIR_IN_I[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode; low mode bits give active-low for pairs A/C and B/D
    assign steer_mode = (st_reg.ccp_cfg[CCP_MODE_LSB+3:CCP_MODE_LSB+2] == CCP_MODE_PWM)
                     && (st_reg.ccp_cfg[PWM_CFG_LSB+1:PWM_CFG_LSB] == PWM_CFG_SINGLE);
    assign pol_a   = st_reg.ccp_cfg[CCP_MODE_LSB+1];
    assign pol_b   = st_reg.ccp_cfg[CCP_MODE_LSB];
    assign new_sel = st_reg.ctrl[STEER_D_BIT:STEER_A_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge MCLK_I) begin
        if (SYS_RST_I) begin
            st_reg          <= '0;
            st_reg.ctrl     <= STEER_CTRL_RESET;
            st_reg.ccp_cfg  <= CCP_CFG_RESET;
            st_reg.applied  <= STEER_CTRL_RESET[3:0];
            st_reg.pin_oe_n <= 4'hf;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops; bus always ready and OKAY
    assign HRDATA_O    = st_reg.hrdata;
    assign HREADYOUT_O = 1'b1;
    assign HRESP_O     = 1'b0;
    assign PIN_OUT_O   = st_reg.pin_out;
    assign PIN_OE_N_O  = st_reg.pin_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    sequence s_sync_hold;
        st_reg.ctrl[STEER_SYNC_BIT] && !PERIOD_START_I && !st_reg.wr.valid;
    endsequence

    property p_sync_defer;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        s_sync_hold |=> st_reg.applied == $past(st_reg.applied);
    endproperty
    a_sync_defer: assert property (p_sync_defer) else $error("deferred update applied");

    property p_sync_period;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        (st_reg.ctrl[STEER_SYNC_BIT] && PERIOD_START_I && !st_reg.wr.valid)
            |=> st_reg.applied == $past(new_sel) && !st_reg.pending;
    endproperty
    a_sync_period: assert property (p_sync_period) else $error("period update missed");

    property p_immediate;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        !st_reg.ctrl[STEER_SYNC_BIT] && !st_reg.wr.valid |=> st_reg.applied == $past(new_sel);
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate update missed");

    property p_pwm_drive;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        steer_mode && st_reg.applied[0] |=> !PIN_OE_N_O[0]
            && PIN_OUT_O[0] == ($past(PWM_I) ^ $past(pol_a));
    endproperty
    a_pwm_drive: assert property (p_pwm_drive) else $error("pin A not PWM");

    property p_port_release;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        !st_reg.applied[3] |=> PIN_OUT_O[3] == $past(PORT_DATA_I[3])
            && PIN_OE_N_O[3] == $past(PORT_DIR_IN_I[3]);
    endproperty
    a_port_release: assert property (p_port_release) else $error("pin D not port");

    property p_bit_map;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        st_reg.wr.valid && st_reg.wr.addr == STEER_CTRL_ADDR
            |=> st_reg.ctrl == ($past(HWDATA_I[7:0]) & STEER_CTRL_MASK);
    endproperty
    a_bit_map: assert property (p_bit_map) else $error("control write wrong");

    property p_mode_gate;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        !steer_mode |=> PIN_OUT_O == $past(PORT_DATA_I);
    endproperty
    a_mode_gate: assert property (p_mode_gate) else $error("steering outside mode");

    property p_keep_prev;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        st_reg.pending && !PERIOD_START_I && st_reg.ctrl[STEER_SYNC_BIT] && !st_reg.wr.valid
            |=> $stable(st_reg.applied) && st_reg.pending;
    endproperty
    a_keep_prev: assert property (p_keep_prev) else $error("pending selection lost");

    // Pins in a pending window still follow the old selection
    property p_keep_pins;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        steer_mode && st_reg.pending
            |=> PIN_OE_N_O == ($past(PORT_DIR_IN_I) & ~$past(st_reg.applied));
    endproperty
    a_keep_pins: assert property (p_keep_pins) else $error("pending pins moved");

    // Pin D takes the B/D polarity bit
    property p_pwm_drive_d;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        steer_mode && st_reg.applied[3] |=> !PIN_OE_N_O[3]
            && PIN_OUT_O[3] == ($past(PWM_I) ^ $past(pol_b));
    endproperty
    a_pwm_drive_d: assert property (p_pwm_drive_d) else $error("pin D not PWM");

    // Control read returns the value in force, reserved bits zero
    property p_ctrl_read;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        HSEL_I && HREADY_I && HTRANS_I == HTRANS_NONSEQ && !HWRITE_I
            && HADDR_I == STEER_CTRL_ADDR |=> HRDATA_O == {24'h000000, $past(wr_ctrl)};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    // Outside steering mode every pin direction is the port's
    property p_mode_gate_oe;
        @(posedge MCLK_I) disable iff (SYS_RST_I)
        !steer_mode |=> PIN_OE_N_O == $past(PORT_DIR_IN_I);
    endproperty
    a_mode_gate_oe: assert property (p_mode_gate_oe) else $error("port pin driven");

endmodule

// ---- pos_pkg.sv ----
// Package for the PWM output steering block: register map, fields, types
package pos_pkg;

    // Register byte addresses on the AHB-Lite slave
    localparam logic [7:0] STEER_CTRL_ADDR   = 8'h00;  // Steering control register
    localparam logic [7:0] CCP_CFG_ADDR      = 8'h04;  // Mode and output config
    localparam logic [7:0] STEER_STAT_ADDR   = 8'h08;  // Applied steering and status

    // Steering control field positions
    localparam int         STEER_A_BIT       = 0;      // Output A enable
    localparam int         STEER_D_BIT       = 3;      // Output D enable
    localparam int         STEER_SYNC_BIT    = 4;      // Sync select
    localparam logic [7:0] STEER_CTRL_RESET  = 8'h01;  // Output A on after reset
    localparam logic [7:0] STEER_CTRL_MASK   = 8'h1f;  // Bits 7..5 read as zero

    // CCP configuration register layout
    localparam int         CCP_MODE_LSB      = 0;      // ccp_mode_field [3:0]
    localparam int         PWM_CFG_LSB       = 4;      // pwm_output_config_field [5:4]
    localparam logic [7:0] CCP_CFG_RESET     = 8'h00;  // Steering disabled
    localparam logic [1:0] CCP_MODE_PWM      = 2'b11;  // Upper mode bits for PWM
    localparam logic [1:0] PWM_CFG_SINGLE    = 2'b00;  // Single-output config

    // AHB transfer type
    localparam logic [1:0] HTRANS_NONSEQ     = 2'b10;  // Only single transfers

    // Bus address phase captured for the data phase
    typedef struct packed {
        logic       valid;    // Pending write data phase
        logic [7:0] addr;     // Captured byte address
    } pos_wr_phase_t;

    // Whole state of the block
    typedef struct packed {
        pos_wr_phase_t wr;            // Pending write
        logic [7:0]    rd_addr;       // Read address captured
        logic [31:0]   hrdata;        // Read data output
        logic [7:0]    ctrl;          // Steering control as written
        logic [7:0]    ccp_cfg;       // Mode and config
        logic [3:0]    applied;       // Steering enables in effect
        logic          pending;       // Deferred update waiting
        logic [3:0]    pin_out;       // Pin data out
        logic [3:0]    pin_oe_n;      // Pin output enable, low drives
    } pos_state_t;

endpackage

// ---- pos_load.sv ----
// External loads on the four steered output pins
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pos_load (
    input  wire logic [3:0] PIN_OUT_I,   // Level the block drives
    input  wire logic [3:0] PIN_OE_N_I,  // Low while the block drives
    output logic      [3:0] PAD_O        // Level seen at the pad
);
    // Released pins sit on a board pull-up, so a stale level never shows
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            PAD_O[i] = PIN_OE_N_I[i] ? 1'b1 : PIN_OUT_I[i];
        end
    end
endmodule

// ---- pos_steer_test.sv ----
// Self-checking bench for the PWM output steering block
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
module pos_steer_test
    import pos_pkg::*;
;
    logic        MCLK_I = 1'b0, SYS_RST_I = 1'b1, HSEL_I = 1'b0, HWRITE_I = 1'b0;
    logic        PWM_I = 1'b0, PERIOD_START_I = 1'b0, HREADYOUT_O, HRESP_O;
    logic [7:0]  HADDR_I = 8'h00;
    logic [1:0]  HTRANS_I = 2'b00;
    logic [31:0] HWDATA_I = 32'h0, HRDATA_O, rd;
    logic [3:0]  PORT_DATA_I = 4'ha, PORT_DIR_IN_I = 4'h6;
    logic [3:0]  PIN_OUT_O, PIN_OE_N_O, pad;
    int          mismatches = 0, compares = 0;

    // 20 MHz clock
    always #25 MCLK_I = ~MCLK_I;

    // The one slave's ready is the bus ready; size is always a word
    pos_steer DUT (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
        .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2),
        .HWDATA_I(HWDATA_I), .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O),
        .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .PWM_I(PWM_I),
        .PERIOD_START_I(PERIOD_START_I), .PORT_DATA_I(PORT_DATA_I),
        .PORT_DIR_IN_I(PORT_DIR_IN_I), .PIN_OUT_O(PIN_OUT_O), .PIN_OE_N_O(PIN_OE_N_O));

    pos_load LOAD (.PIN_OUT_I(PIN_OUT_O), .PIN_OE_N_I(PIN_OE_N_O), .PAD_O(pad));

    ////////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic test_done();
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Compare one result
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Wait for hready under a bound; a stuck slave ends the run
    task automatic rdy();
        int n;
        n = 0;
        do begin
            @(posedge MCLK_I);
            n++;
        end while (HREADYOUT_O !== 1'b1 && n < 20);
        if (HREADYOUT_O !== 1'b1) begin
            mismatches++;
            test_done();
        end
    endtask

    // One single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        HSEL_I   <= 1'b1;
        HTRANS_I <= HTRANS_NONSEQ;
        HADDR_I  <= a;
        HWRITE_I <= wr;
        rdy();
        HSEL_I   <= 1'b0;
        HTRANS_I <= 2'b00;
        HWDATA_I <= wd;
        rdy();
        rd = HRDATA_O;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
        chk({31'h0, HRESP_O}, 32'h0);
    endtask

    // Applied set and pins each lag a clock, so let both settle first
    task automatic pins(input logic [3:0] en, input logic [1:0] m);
        logic [3:0] inv, eo, eoe;
        repeat (3) @(posedge MCLK_I);
        inv = {m[0], m[1], m[0], m[1]};
        eo  = (en & ({4{PWM_I}} ^ inv)) | (~en & PORT_DATA_I);
        eoe = ~en & PORT_DIR_IN_I;
        chk({24'h0, PIN_OE_N_O, PIN_OUT_O}, {24'h0, eoe, eo});
        chk({28'h0, pad}, {28'h0, eo | eoe});
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (8) @(posedge MCLK_I);
        SYS_RST_I <= 1'b0;
        @(posedge MCLK_I);
        rdchk(STEER_CTRL_ADDR, 32'h01);
        rdchk(CCP_CFG_ADDR, 32'h00);
        pins(4'h0, 2'b00);
        bus(1'b1, STEER_CTRL_ADDR, 32'hff);
        rdchk(STEER_CTRL_ADDR, 32'h1f);
        rdchk(8'h0c, 32'h00);
        // Every polarity, every single enable, both PWM levels
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, CCP_CFG_ADDR, 32'h0c | m);
            for (int i = 0; i < 4; i++) begin
                bus(1'b1, STEER_CTRL_ADDR, 32'h1 << i);
                for (int p = 0; p < 2; p++) begin
                    PWM_I <= p[0];
                    pins(4'h1 << i, m[1:0]);
                end
            end
        end
        // Wrong output config, then wrong mode: pins go back to the port
        bus(1'b1, CCP_CFG_ADDR, 32'h1c);
        pins(4'h0, 2'b00);
        bus(1'b1, CCP_CFG_ADDR, 32'h08);
        pins(4'h0, 2'b00);
        // Deferred update holds the old set until a period starts
        PORT_DATA_I   <= 4'h5;
        PORT_DIR_IN_I <= 4'h9;
        bus(1'b1, CCP_CFG_ADDR, 32'h0c);
        bus(1'b1, STEER_CTRL_ADDR, 32'h13);
        pins(4'h8, 2'b00);
        repeat (20) @(posedge MCLK_I);
        pins(4'h8, 2'b00);
        bus(1'b0, STEER_STAT_ADDR, 32'h0);
        chk(rd & 32'h2f, 32'h28);
        PERIOD_START_I <= 1'b1;
        @(posedge MCLK_I);
        PERIOD_START_I <= 1'b0;
        pins(4'h3, 2'b00);
        bus(1'b0, STEER_STAT_ADDR, 32'h0);
        chk(rd & 32'h2f, 32'h03);
        // Reset again mid-run: control and config return, pins go to the port
        SYS_RST_I <= 1'b1;
        repeat (2) @(posedge MCLK_I);
        SYS_RST_I <= 1'b0;
        @(posedge MCLK_I);
        rdchk(STEER_CTRL_ADDR, {24'h000000, STEER_CTRL_RESET});
        rdchk(CCP_CFG_ADDR, {24'h000000, CCP_CFG_RESET});
        pins(4'h0, 2'b00);
        test_done();
    end
endmodule
